// >>> hw/smpc_pkg.sv
// Package with register map, field positions and reset values of the sleep controller
package smpc_pkg;
    localparam logic [11:0] ADDR_CLKEN    = 12'h008;
    localparam logic [11:0] ADDR_CTRL     = 12'h010;
    localparam logic [11:0] ADDR_STATUS   = 12'h014;
    localparam logic [11:0] ADDR_WAKESRC  = 12'h018;
    localparam logic [11:0] ADDR_WAKEEN   = 12'h01c;

    localparam int CLKEN_XTAL_BIT = 0;
    localparam int CLKEN_RC_BIT   = 1;
    localparam logic [1:0] CLKEN_RESET = 2'h2;

    localparam int CTRL_WAKECORE_BIT = 0;

    localparam int NUM_WAKE = 9;
    localparam int WK_GPIO  = 0;
    localparam int WK_SER1  = 1;
    localparam int WK_SER2  = 2;
    localparam int WK_IRQ   = 3;
    localparam int WK_DBG   = 4;
    localparam int WK_SYS   = 5;
    localparam int WK_CMPA  = 6;
    localparam int WK_CMPB  = 7;
    localparam int WK_WRAP  = 8;
    localparam int WK_CORE  = 9;
    localparam int NUM_SRC  = 10;
    localparam logic [NUM_SRC-1:0] WAKEEN_RESET = 10'h3ff;

    localparam int GPIO_W = 24;
    localparam int RESET_HOLD = 4;
    localparam logic [2:0] RESET_HOLD_CNT = 3'h4;

    typedef enum logic [2:0] {
        PS_RUN, PS_IDLE, PS_PRE, PS_DS0, PS_DS1, PS_DS2, PS_WAKE
    } smpc_state_e;
endpackage

// >>> hw/smpc_top.sv
// Sleep mode power controller: state machine, wake recording and APB registers
// Summary of operation
// - Clock enable bit 1 keeps the low-frequency RC oscillator on in deep sleep.
// - Clock enable bit 0 turns on the low-frequency crystal oscillator.
// - Idle sleep halts CPU until an interrupt; nothing unpowered or reset.
// - Deep sleep 1 powers down the core domain; sleep timer stays active.
// - Deep sleep 2 is deep sleep 1 without the sleep timer wakes unless the crystal is on.
// - Deep sleep 0 keeps core powered, resets peripherals except debug parts.
// - Deep sleep 1 and 2 wake on pin changes or debug power-up requests.
// - Sleep timer compare A, B and wrap wake from deep sleep 0 and 1, and from deep sleep 2 with the crystal on.
// - Core wake register write wakes only from deep sleep 0.
// - Wake sources are recorded always, several at once.
// - WFI enters idle sleep, or deep sleep when the deep flag is set.
// - Deep sleep request waits in pre-deep-sleep until system power request clears.
// - Waking from deep sleep runs a processor reset cycle first.
// - Without RC oscillator, timers wake from deep sleep 2 only on crystal.
// - Waking from deep sleep 2 re-enables the RC oscillator.
// - With debug power request set, only deep sleep 0 is entered.
// - Both debug requests must clear before deep sleep 1 or 2.
// - Debug accesses stall while the chip is in deep sleep 1 or 2.
// - Internal regulators are disabled in deep sleep 1 and 2.
// - Open-drain regulator pin driven low in deep sleep 1 and 2, released otherwise.
`timescale 1ns/1ps
module smpc_top
    import smpc_pkg::*;
(
    input  wire logic                    i_clk,         // 50 MHz clock
    input  wire logic                    i_resetn,      // Async reset, low
    input  wire logic                    i_psel,        // APB select
    input  wire logic                    i_penable,     // APB enable
    input  wire logic                    i_pwrite,      // APB write
    input  wire logic [11:0]             i_paddr,       // APB byte address
    input  wire logic [31:0]             i_pwdata,      // APB write data
    output logic      [31:0]             o_prdata,      // APB read data
    output logic                         o_pready,      // APB ready
    output logic                         o_pslverr,     // APB error
    input  wire logic                    i_wfi,         // CPU executes WFI
    input  wire logic                    i_sleepdeep,   // Deep flag of control reg
    input  wire logic                    i_irq,         // Any pending interrupt
    input  wire logic [GPIO_W-1:0]       i_gpio,        // GPIO pins (async)
    input  wire logic                    i_serial1_wake_pin, // Serial 1 wake
    input  wire logic                    i_serial2_wake_pin, // Serial 2 wake
    input  wire logic                    i_sel_pin_irq, // Selectable pin irq
    input  wire logic                    i_cdbgpwrupreq, // Debug power request
    input  wire logic                    i_csyspwrupreq, // System power request
    input  wire logic                    i_tmr_cmpa,    // Timer compare A pulse
    input  wire logic                    i_tmr_cmpb,    // Timer compare B pulse
    input  wire logic                    i_tmr_wrap,    // Timer wrap pulse
    output logic                         o_cpu_halt,    // Halt CPU (idle)
    output logic                         o_core_pwr_en, // Core domain power
    output logic                         o_periph_rst,  // Hold peripherals reset
    output logic                         o_cpu_rst,     // Processor reset
    output logic                         o_rc_en,       // RC oscillator enable
    output logic                         o_xtal_en,     // Crystal enable
    output logic                         o_vreg_en,     // Internal regulators
    output logic                         o_regen_o,     // Reg pin output level
    output logic                         o_regen_oe,    // Reg pin enable, low
    output logic                         o_dbg_stall    // Hold off debugger
);
    import smpc_pkg::*;

    smpc_state_e                 state_r;
    logic [1:0]                  clken_r;
    logic                        wakecore_r;
    logic [NUM_SRC-1:0]          wake_rec_r;
    logic [NUM_SRC-1:0]          wake_en_r;
    logic [2:0]                  rst_cnt_r;
    logic                        from_ds2_r;
    logic [GPIO_W+3:0]           pin_s1_r;
    logic [GPIO_W+3:0]           pin_s2_r;
    logic [GPIO_W+3:0]           pin_s3_r;
    logic [1:0]                  dbg_s1_r;
    logic [1:0]                  dbg_s2_r;
    logic [1:0]                  dbg_s3_r;
    logic [NUM_SRC-1:0]          ev;
    logic [NUM_SRC-1:0]          valid_msk;
    logic                        wake_hit;
    logic                        wr;
    logic                        rd;
    logic [GPIO_W+3:0]           pin_chg;
    logic                        dbg_req;
    logic                        sys_req;
    logic                        deep_now;

    // Three-stage synchronisers; a pin change counts while stage 2 and 3 differ, a debug request only on its rise
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            pin_s3_r <= '0;
            dbg_s1_r <= 2'h0;
            dbg_s2_r <= 2'h0;
            dbg_s3_r <= 2'h0;
        end else begin
            pin_s1_r <= {i_sel_pin_irq, i_serial2_wake_pin,
                         i_serial1_wake_pin, 1'b0, i_gpio};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            dbg_s1_r <= {i_csyspwrupreq, i_cdbgpwrupreq};
            dbg_s2_r <= dbg_s1_r;
            dbg_s3_r <= dbg_s2_r;
        end
    end

    assign pin_chg = pin_s2_r ^ pin_s3_r;
    assign dbg_req = dbg_s3_r[0];
    assign sys_req = dbg_s3_r[1];

    // Core domain is really unpowered only in deep sleep 1 and 2
    assign deep_now = state_r == PS_DS1 || state_r == PS_DS2;

    // Events seen every cycle, whatever the state
    always_comb begin
        ev = '0;
        ev[WK_GPIO] = |pin_chg[GPIO_W-1:0];
        ev[WK_SER1] = pin_chg[GPIO_W+1];
        ev[WK_SER2] = pin_chg[GPIO_W+2];
        ev[WK_IRQ]  = pin_chg[GPIO_W+3];
        ev[WK_DBG]  = dbg_s2_r[0] & ~dbg_s3_r[0];
        ev[WK_SYS]  = dbg_s2_r[1] & ~dbg_s3_r[1];
        ev[WK_CMPA] = i_tmr_cmpa;
        ev[WK_CMPB] = i_tmr_cmpb;
        ev[WK_WRAP] = i_tmr_wrap;
        ev[WK_CORE] = wakecore_r;
    end

    // Which sources may wake from the present state
    // Outside the deep states nothing wakes, but everything is still recorded
    always_comb begin
        valid_msk = '0;
        case (state_r)
            PS_DS1: valid_msk = 10'h1ff;
            // Timer wakes only survive when the crystal keeps timing
            PS_DS2: valid_msk = clken_r[CLKEN_XTAL_BIT] ?
                                10'h1ff : 10'h03f;
            PS_DS0: valid_msk = 10'h3ff;
            default: valid_msk = '0;
        endcase
    end

    assign wake_hit = |(ev & valid_msk & wake_en_r);

    assign wr = i_psel & i_penable & i_pwrite;
    assign rd = i_psel & ~i_penable & ~i_pwrite;

    // Power state machine
    // Idle is left on any interrupt; the deep states only on a wake hit
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_r    <= PS_RUN;
            rst_cnt_r  <= 3'h0;
            from_ds2_r <= 1'b0;
        end else begin
            case (state_r)
                PS_RUN: begin
                    // A pending interrupt turns an idle request into a no-op
                    if (i_wfi && !i_sleepdeep && !i_irq) begin
                        state_r <= PS_IDLE;
                    end else if (i_wfi && i_sleepdeep) begin
                        state_r <= PS_PRE;
                    end
                end
                PS_IDLE: begin
                    if (i_irq) begin
                        state_r <= PS_RUN;
                    end
                end
                PS_PRE: begin
                    // Nothing is gated while the debugger still wants
                    // memory; the debug request seen at release decides
                    if (!sys_req) begin
                        if (dbg_req) begin
                            state_r <= PS_DS0;
                        end else if (clken_r[CLKEN_RC_BIT]) begin
                            state_r <= PS_DS1;
                        end else begin
                            state_r <= PS_DS2;
                        end
                    end
                end
                PS_DS0, PS_DS1, PS_DS2: begin
                    if (wake_hit) begin
                        from_ds2_r <= (state_r == PS_DS2);
                        rst_cnt_r  <= RESET_HOLD_CNT;
                        state_r    <= PS_WAKE;
                    end
                end
                PS_WAKE: begin
                    // Reset is held one cycle longer than the count value
                    if (rst_cnt_r == 3'h0) begin
                        state_r <= PS_RUN;
                    end else begin
                        rst_cnt_r <= rst_cnt_r - 3'h1;
                    end
                end
                default: state_r <= PS_RUN;
            endcase
        end
    end

    // Wake record: set wins over a software clear
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wake_rec_r <= '0;
        end else begin
            if (wr && i_paddr == ADDR_WAKESRC) begin
                wake_rec_r <= (wake_rec_r & ~i_pwdata[NUM_SRC-1:0]) | ev;
            end else begin
                wake_rec_r <= wake_rec_r | ev;
            end
        end
    end

    // Clock source enables; a software write wins over the wake restore
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            clken_r <= CLKEN_RESET;
        end else if (wr && i_paddr == ADDR_CLKEN) begin
            clken_r <= i_pwdata[1:0];
        end else if (state_r == PS_WAKE && from_ds2_r) begin
            clken_r[CLKEN_RC_BIT] <= 1'b1;
        end
    end

    // Wake source enables
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wake_en_r <= WAKEEN_RESET;
        end else if (wr && i_paddr == ADDR_WAKEEN) begin
            wake_en_r <= i_pwdata[NUM_SRC-1:0];
        end
    end

    // Core wake request: a one-cycle pulse, so it cannot wake twice
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wakecore_r <= 1'b0;
        end else begin
            wakecore_r <= wr && i_paddr == ADDR_CTRL &&
                          i_pwdata[CTRL_WAKECORE_BIT];
        end
    end

    // APB slave: setup cycle latches the read data, access ends in one cycle
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_prdata  <= 32'h0;
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready  <= i_psel & ~i_penable;
            o_pslverr <= 1'b0;
            if (i_psel && !i_penable) begin
                o_prdata <= 32'h0;
                case (i_paddr)
                    ADDR_CLKEN:   o_prdata <= {30'h0, clken_r};
                    ADDR_CTRL:    o_prdata <= 32'h0;
                    ADDR_STATUS:  o_prdata <= {29'h0, state_r};
                    ADDR_WAKESRC: o_prdata <= {22'h0, wake_rec_r};
                    ADDR_WAKEEN:  o_prdata <= {22'h0, wake_en_r};
                    default:      o_pslverr <= 1'b0;
                endcase
                if (!rd) begin
                    o_prdata <= 32'h0;
                end
                o_pslverr <= !(i_paddr == ADDR_CLKEN ||
                               i_paddr == ADDR_CTRL ||
                               i_paddr == ADDR_STATUS ||
                               i_paddr == ADDR_WAKESRC ||
                               i_paddr == ADDR_WAKEEN);
            end
        end
    end

    // Power and reset outputs, registered from the state, one per concern
    // Core halted in every state but running
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_cpu_halt <= 1'b0;
        end else begin
            o_cpu_halt <= state_r != PS_RUN;
        end
    end

    // Core domain power; deep sleep 0 keeps it on for the debugger
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_core_pwr_en <= 1'b1;
        end else begin
            o_core_pwr_en <= !deep_now;
        end
    end

    // Peripherals stay in reset through the wake reset cycle too
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_periph_rst <= 1'b0;
        end else begin
            o_periph_rst <= state_r == PS_DS0 ||
                            state_r == PS_WAKE;
        end
    end

    // Processor reset cycle on the way back from any deep state
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_cpu_rst <= 1'b0;
        end else begin
            o_cpu_rst <= state_r == PS_WAKE;
        end
    end

    // RC oscillator only stops in deep sleep 2 with its bit clear
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rc_en <= 1'b1;
        end else begin
            o_rc_en <= state_r != PS_DS2 ||
                       clken_r[CLKEN_RC_BIT];
        end
    end

    // Crystal follows its enable bit in every state
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_xtal_en <= 1'b0;
        end else begin
            o_xtal_en <= clken_r[CLKEN_XTAL_BIT];
        end
    end

    // Internal regulators off whenever the core domain is off
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_vreg_en <= 1'b1;
        end else begin
            o_vreg_en <= !deep_now;
        end
    end

    // Open-drain pin: level is always low, the enable alone decides
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_regen_o <= 1'b0;
        end else begin
            o_regen_o <= 1'b0;
        end
    end

    // Driven low in deep sleep 1 and 2; released so the pull-up asks for supply
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_regen_oe <= 1'b1;
        end else begin
            o_regen_oe <= !deep_now;
        end
    end

    // Debugger held off until the core is powered and out of reset
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_dbg_stall <= 1'b0;
        end else begin
            o_dbg_stall <= deep_now || state_r == PS_WAKE;
        end
    end

endmodule // smpc_top

// >>> bench/smpc_asserts.sv
// Assertion checker for the sleep mode power controller
`timescale 1ns/1ps
module smpc_asserts
    import smpc_pkg::*;
(
    input wire logic        i_clk,          // Clock
    input wire logic        i_resetn,       // Reset, low
    input wire logic        i_psel,         // APB select
    input wire logic        i_penable,      // APB enable
    input wire logic        i_pwrite,       // APB write
    input wire logic [11:0] i_paddr,        // APB address
    input wire logic [31:0] i_pwdata,       // APB write data
    input wire logic        o_pready,       // APB ready
    input wire logic        i_cdbgpwrupreq, // Debug request
    input wire logic        i_csyspwrupreq, // System request
    input wire logic        o_cpu_halt,     // CPU halt
    input wire logic        o_core_pwr_en,  // Core power
    input wire logic        o_periph_rst,   // Peripheral reset
    input wire logic        o_cpu_rst,      // CPU reset
    input wire logic        o_rc_en,        // RC enable
    input wire logic        o_xtal_en,      // Crystal enable
    input wire logic        o_vreg_en,      // Regulators
    input wire logic        o_regen_o,      // Reg pin level
    input wire logic        o_regen_oe,     // Reg pin enable
    input wire logic        o_dbg_stall     // Debug stall
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    logic       clken_wr;
    logic [1:0] clken_r;
    assign clken_wr = i_psel && i_penable && i_pwrite && o_pready
                      && i_paddr == ADDR_CLKEN;
    // Shadow of the last enable write; outputs may lag it by two edges
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn)
            clken_r <= CLKEN_RESET;
        else if (clken_wr)
            clken_r <= i_pwdata[1:0];
    end
    AST_RC_WR: assert property (clken_wr |-> ##2 (o_rc_en || !clken_r[1]))
        else $error("RC enable does not follow its bit");
    AST_RC_AWAKE: assert property (o_core_pwr_en |-> o_rc_en)
        else $error("RC oscillator stopped while core powered");
    AST_XTAL_WR: assert property (clken_wr |-> ##2 o_xtal_en == clken_r[0])
        else $error("Crystal enable does not follow its bit");
    AST_DS_PINS: assert property (!o_regen_o &&
            o_regen_oe == o_core_pwr_en && o_vreg_en == o_core_pwr_en)
        else $error("Regulator controls not tied to deep sleep");
    AST_DS_STALL: assert property (!o_core_pwr_en |-> o_dbg_stall)
        else $error("Debugger not held off in deep sleep");
    AST_RST_CTX: assert property (o_cpu_rst |->
            o_cpu_halt && o_periph_rst && o_core_pwr_en)
        else $error("Processor reset outside powered wake");
    AST_RST_LEN: assert property ($rose(o_cpu_rst) |->
            o_cpu_rst [*5] ##1 !o_cpu_rst)
        else $error("Processor reset length wrong");
    AST_PWRUP: assert property ($rose(o_core_pwr_en) |-> o_cpu_rst)
        else $error("Core powered up without processor reset");
    AST_DBG_DS0: assert property (i_cdbgpwrupreq [*8] |-> o_core_pwr_en)
        else $error("Core unpowered while debugger attached");
    AST_SYS_PRE: assert property (i_csyspwrupreq [*8] |-> o_core_pwr_en)
        else $error("Core unpowered while system request set");
endmodule // smpc_asserts
bind smpc_top smpc_asserts smpc_asserts_i (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_pready(o_pready),
    .i_cdbgpwrupreq(i_cdbgpwrupreq), .i_csyspwrupreq(i_csyspwrupreq),
    .o_cpu_halt(o_cpu_halt), .o_core_pwr_en(o_core_pwr_en),
    .o_periph_rst(o_periph_rst), .o_cpu_rst(o_cpu_rst), .o_rc_en(o_rc_en),
    .o_xtal_en(o_xtal_en), .o_vreg_en(o_vreg_en), .o_regen_o(o_regen_o),
    .o_regen_oe(o_regen_oe), .o_dbg_stall(o_dbg_stall));

// >>> bench/smpc_core_model.sv
// Model of the processor core and debug port driving the sleep requests
`timescale 1ns/1ps
module smpc_core_model (
    input  wire logic i_clk,  // Clock
    input  wire logic i_halt, // CPU halted
    output logic      o_wfi,  // WFI executed
    output logic      o_deep, // Deep sleep flag
    output logic      o_irq,  // Interrupt pending
    output logic      o_cdbg, // Debug power request
    output logic      o_csys  // System power request
);
    initial {o_wfi, o_deep, o_irq, o_cdbg, o_csys} = 5'h0;
    task automatic sleep(input logic deep);
        @(posedge i_clk);
        o_deep <= deep;
        o_wfi  <= 1'b1;
        @(posedge i_clk);
        o_wfi  <= 1'b0;
    endtask
    // Interrupt stays pending until the core has really left the halt
    task automatic interrupt();
        int n;
        n = 0;
        @(posedge i_clk);
        o_irq <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
        end while (i_halt !== 1'b0 && n < 30);
        o_irq <= 1'b0;
    endtask
    task automatic dbg(input logic cd, input logic cs);
        @(posedge i_clk);
        o_cdbg <= cd;
        o_csys <= cs;
        // Let the level pass the three-stage synchroniser before going on
        repeat (4) @(posedge i_clk);
    endtask
endmodule // smpc_core_model

// >>> bench/smpc_top_tb.sv
// Self-checking testbench of the sleep mode power controller
`timescale 1ns/1ps
module smpc_top_tb;
    import smpc_pkg::*;
    logic              i_clk = 1'b0, i_resetn = 1'b0;
    logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]       paddr = 12'h0;
    logic [31:0]       pwdata = 32'h0, q;
    logic [5:0]        ev = 6'h0; // Serial pins, irq pin, timer pulses
    logic [GPIO_W-1:0] gpio = '0;
    logic              e;
    wire  [31:0]       prdata;
    wire  [6:0]        outs;
    wire               pready, pslverr, wfi, deep, irq, cdbg, csys;
    wire               rc_en, xtal_en;
    int                bad_count = 0, tests_run = 0, seed = 31;
    smpc_core_model smpc_core_model_i (.i_clk(i_clk), .i_halt(outs[6]),
        .o_wfi(wfi), .o_deep(deep), .o_irq(irq), .o_cdbg(cdbg), .o_csys(csys));
    smpc_top smpc_top_i (.i_clk(i_clk), .i_resetn(i_resetn), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_wfi(wfi), .i_sleepdeep(deep), .i_irq(irq),
        .i_gpio(gpio), .i_serial1_wake_pin(ev[0]), .i_serial2_wake_pin(ev[1]),
        .i_sel_pin_irq(ev[2]), .i_cdbgpwrupreq(cdbg), .i_csyspwrupreq(csys),
        .i_tmr_cmpa(ev[3]), .i_tmr_cmpb(ev[4]), .i_tmr_wrap(ev[5]),
        .o_cpu_halt(outs[6]), .o_core_pwr_en(outs[5]), .o_periph_rst(outs[4]),
        .o_cpu_rst(outs[3]), .o_rc_en(rc_en), .o_xtal_en(xtal_en),
        .o_vreg_en(outs[2]), .o_regen_o(), .o_regen_oe(outs[1]),
        .o_dbg_stall(outs[0]));
    // Expected halt, power, periph reset, cpu reset, vreg, pin enable, stall
    function automatic logic [6:0] m_out(input int s);
        logic ds;
        ds = (s == 4 || s == 5);
        return {s != 0, !ds, s == 3 || s == 6, s == 6, !ds, !ds, ds || s == 6};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) bad_count++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q, x);
    endtask
    // Polls state code; the wake state lasts only a few cycles
    task automatic st_is(input int s);
        int n;
        n = 0;
        do begin
            apb(1'b0, ADDR_STATUS, 32'h0);
            n++;
        end while (q !== 32'(s) && n < 40);
        chk(q, 32'(s));
        if (s != 6) chk({25'h0, outs}, {25'h0, m_out(s)});
    endtask
    task automatic kick(input int k);
        @(posedge i_clk);
        ev[k] <= ~ev[k];
        if (k > 2) begin
            @(posedge i_clk);
            ev[k] <= 1'b0;
        end
    endtask
    task automatic end_sim();
        if (bad_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        forever #10 i_clk = ~i_clk;
    end
    initial begin
        #400000;
        bad_count++;
        end_sim();
    end
    initial begin
        repeat (6) @(posedge i_clk);
        i_resetn <= 1'b1;
        st_is(0);
        rd(ADDR_CLKEN, {30'h0, CLKEN_RESET});
        rd(ADDR_WAKEEN, {22'h0, WAKEEN_RESET});
        rd(12'hffc, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, ADDR_CLKEN, 32'h3);
        repeat (2) @(posedge i_clk);
        chk({30'h0, rc_en, xtal_en}, 32'h3);
        smpc_core_model_i.sleep(1'b0);
        st_is(1);
        smpc_core_model_i.interrupt();
        st_is(0);
        for (int k = 0; k < 6; k++) begin
            if (k == 0) smpc_core_model_i.dbg(1'b0, 1'b1);
            smpc_core_model_i.sleep(1'b1);
            if (k == 0) begin
                repeat (12) @(posedge i_clk);
                st_is(2);
                smpc_core_model_i.dbg(1'b0, 1'b0);
            end
            st_is(4);
            kick(k);
            st_is(6);
            st_is(0);
        end
        apb(1'b1, ADDR_CLKEN, 32'h0);
        apb(1'b1, ADDR_WAKESRC, 32'h3ff);
        smpc_core_model_i.sleep(1'b1);
        st_is(5);
        kick(4);
        apb(1'b1, ADDR_CTRL, 32'h1);
        st_is(5);
        @(posedge i_clk);
        gpio <= gpio ^ (24'h1 << ($unsigned($random(seed)) % GPIO_W));
        st_is(6);
        st_is(0);
        rd(ADDR_CLKEN, 32'h2);
        rd(ADDR_WAKESRC, (1 << WK_GPIO) | (1 << WK_CMPB) | (1 << WK_CORE));
        smpc_core_model_i.dbg(1'b1, 1'b0);
        smpc_core_model_i.sleep(1'b1);
        st_is(3);
        apb(1'b1, ADDR_CTRL, 32'h1);
        st_is(6);
        st_is(0);
        end_sim();
    end
endmodule // smpc_top_tb
